// [adc_fe_cfg.sv]
// adc front-end configuration registers with axi4-lite access and clock-source select
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Notes on behaviour
// - bit 7 picks internal or external converter clock
// - bit 6 picks bipolar or unipolar range
// - two's complement only while range is bipolar
// - p-side reference buffer on, or bypassed
// - n-side reference buffer on, or bypassed
// - reference field picks pair; code 7 reserved
// - bias mode: active, high-z, low-z twice
// - enabling bias clears that input's excitation
// - enabling excitation clears that input's bias
// - burnout field: off, low, middle, high
// - excitation field: sixteen rising levels
// ----------------------------------------------------------------
module adc_fe_cfg
  import adc_fe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic internal_clk_tick,
  input wire logic external_clock_pin,
  output logic conv_tick,
  output fe_cfg_t fe_cfg,
  output logic [NUM_AIN-1:0] bias_en,
  output logic [NUM_AIN-1:0] exc_en
);
  // ----------------------------------------------------------------
  // register-side strobes from the bus slave
  // ----------------------------------------------------------------
  logic wr_en; // one-cycle write pulse
  logic [5:0] wr_idx; // index of the written register
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // byte lanes of the write
  logic [5:0] rd_idx; // index being read
  logic [31:0] rd_data; // read mux into the slave
  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  ctrl_fields_t ctrl_reg; // converter control byte
  src_fields_t src_reg; // source byte
  logic [NUM_AIN-1:0] bias_en_reg; // bias switch per input
  logic [NUM_AIN-1:0] exc_en_reg; // excitation switch per input
  logic [NUM_AIN-1:0] bias_en_next; // bias after a write
  logic [NUM_AIN-1:0] exc_en_next; // excitation after a write
  logic [NUM_AIN-1:0] wr_mask; // lanes of the 12-bit enables that a write reaches
  logic [NUM_AIN-1:0] wr_en_bits; // write data limited to the enables
  // ----------------------------------------------------------------
  // external clock pin conditioning
  // ----------------------------------------------------------------
  logic ext_meta_reg; // first synchroniser stage
  logic ext_sync_reg; // second synchroniser stage
  logic ext_prev_reg; // previous synchronised level
  logic ext_rise; // one-cycle pulse per pin rising edge

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  axil_reg_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // control and source bytes
  // ----------------------------------------------------------------
  // control byte: lane 0 only, every field writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_en && wr_idx == CTRL_IDX && wr_strb[0]) begin
      ctrl_reg <= wr_data[7:0];
    end
  end

  // source byte: lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_reg <= SRC_RST;
    end else if (wr_en && wr_idx == SRC_IDX && wr_strb[0]) begin
      src_reg <= wr_data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // per-input bias and excitation switches
  // ----------------------------------------------------------------
  // lane 0 reaches bits 7:0, lane 1 bits 11:8
  assign wr_mask = {{4{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_en_bits = wr_data[NUM_AIN-1:0];

  // a switch turned on drops the other source on the same input, so
  // the two can never drive one pin even for a cycle
  always_comb begin
    bias_en_next = bias_en_reg;
    exc_en_next = exc_en_reg;
    if (wr_en && wr_idx == BIAS_EN_IDX) begin
      bias_en_next = (bias_en_reg & ~wr_mask) | (wr_en_bits & wr_mask);
      exc_en_next = exc_en_reg & ~(bias_en_next & ~bias_en_reg);
    end else if (wr_en && wr_idx == EXC_EN_IDX) begin
      exc_en_next = (exc_en_reg & ~wr_mask) | (wr_en_bits & wr_mask);
      bias_en_next = bias_en_reg & ~(exc_en_next & ~exc_en_reg);
    end
  end

  // both switch words update together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_en_reg <= EN_RST;
      exc_en_reg <= EN_RST;
    end else begin
      bias_en_reg <= bias_en_next;
      exc_en_reg <= exc_en_next;
    end
  end

  assign bias_en = bias_en_reg;
  assign exc_en = exc_en_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped indices read zero; the slave marks them with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_idx)
      CTRL_IDX: rd_data[7:0] = ctrl_reg;
      SRC_IDX: rd_data[7:0] = src_reg;
      BIAS_EN_IDX: rd_data[NUM_AIN-1:0] = bias_en_reg;
      EXC_EN_IDX: rd_data[NUM_AIN-1:0] = exc_en_reg;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // field decode into analog controls
  // ----------------------------------------------------------------
  fe_cfg_decode u_decode (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(ctrl_reg),
    .src(src_reg),
    .cfg(fe_cfg)
  );

  // ----------------------------------------------------------------
  // converter clock source
  // ----------------------------------------------------------------
  // pin is asynchronous: two stages before anything looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= external_clock_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_rise = ext_sync_reg && !ext_prev_reg;

  // the external pin must run below half of aclk or edges are lost
  assign conv_tick = fe_cfg.clk_ext ? ext_rise : internal_clk_tick;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_values:
    assert property ($rose(aresetn) |-> ctrl_reg == CTRL_RST && src_reg == SRC_RST)
    else $error("config bytes wrong after reset");

  a_ctrl_write:
    assert property (wr_en && wr_idx == CTRL_IDX && wr_strb[0]
                     |=> ctrl_reg == $past(wr_data[7:0]))
    else $error("control byte did not take written value");

  a_src_readback:
    assert property (arvalid && arready && rd_idx == SRC_IDX
                     |=> rvalid && rdata[7:0] == $past(src_reg) && rresp == RESP_OKAY)
    else $error("source byte read back wrong");

  a_clk_source:
    assert property ($past(ctrl_reg.clk_ext) == 1'b0 && !fe_cfg.clk_ext
                     |-> conv_tick == internal_clk_tick)
    else $error("converter tick not from internal clock");

  a_clk_external:
    assert property (fe_cfg.clk_ext && $past(external_clock_pin, 2)
                     && !$past(external_clock_pin, 3) |-> conv_tick)
    else $error("external pin edge did not tick converter");

  a_range_follow:
    assert property (wr_en && wr_idx == CTRL_IDX && wr_strb[0]
                     |=> ##1 fe_cfg.unipolar == $past(wr_data[6], 2))
    else $error("range select did not follow control write");

  a_twos_only_bipolar:
    assert property (fe_cfg.twos_comp |-> !fe_cfg.unipolar && !fe_cfg.offset_bin)
    else $error("two's complement with unipolar range");

  a_format_code:
    assert property (##1 fe_cfg.offset_bin == $past(ctrl_reg.fmt_offset))
    else $error("format bit decoded wrong");

  a_refbuf_p:
    assert property (##1 fe_cfg.refbuf_p_on == $past(ctrl_reg.refbuf_p)
                     && fe_cfg.refbuf_p_bypass == !fe_cfg.refbuf_p_on)
    else $error("p-side buffer control wrong");

  a_refbuf_n:
    assert property (##1 fe_cfg.refbuf_n_on == $past(ctrl_reg.refbuf_n)
                     && fe_cfg.refbuf_n_bypass == !fe_cfg.refbuf_n_on)
    else $error("n-side buffer control wrong");

  a_ref_reserved:
    assert property (##1 fe_cfg.ref_reserved == ($past(ctrl_reg.ref_sel) == REF_RESERVED)
                     && fe_cfg.ref_code == $past(ctrl_reg.ref_sel))
    else $error("reference select decoded wrong");

  a_bias_mode:
    assert property (##1 $onehot({fe_cfg.bias_active, fe_cfg.bias_high_z, fe_cfg.bias_low_z})
                     && fe_cfg.bias_low_z == $past(src_reg.bias_mode[1]))
    else $error("bias mode decoded wrong");

  a_bias_clears_exc:
    assert property (wr_en && wr_idx == BIAS_EN_IDX && (exc_en_reg & bias_en_next) != '0
                     |=> (exc_en_reg & $past(bias_en_next)) == '0)
    else $error("bias enable left excitation on");

  a_exc_clears_bias:
    assert property (wr_en && wr_idx == EXC_EN_IDX && (bias_en_reg & exc_en_next) != '0
                     |=> (bias_en_reg & $past(exc_en_next)) == '0)
    else $error("excitation enable left bias on");

  a_never_both:
    assert property ((bias_en_reg & exc_en_reg) == '0)
    else $error("bias and excitation on one input");

  a_burnout:
    assert property (##1 fe_cfg.burnout_on == ($past(src_reg.burnout) != BURN_OFF)
                     && $countones(fe_cfg.burnout_level) == 32'(fe_cfg.burnout_on))
    else $error("burnout decode wrong");

  a_exc_top:
    assert property ($past(src_reg.exc_level) == 4'hF |-> fe_cfg.exc_ua == EXC_MAX_UA)
    else $error("top excitation level wrong");

  a_exc_rising:
    assert property ($past(src_reg.exc_level) > $past(src_reg.exc_level, 2)
                     |-> fe_cfg.exc_ua > $past(fe_cfg.exc_ua))
    else $error("excitation level not rising with code");

  a_write_answer:
    assert property (wr_en |=> bvalid)
    else $error("write response did not follow the write");

  a_read_answer:
    assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data did not follow the address");

  a_unmapped_write:
    assert property (wr_en && !idx_mapped(wr_idx)
                     |=> bresp == RESP_SLVERR && $stable(ctrl_reg) && $stable(src_reg))
    else $error("unmapped write answered or stored wrong");

  a_burnout_level:
    assert property (##1 fe_cfg.burnout_level
                     == {$past(src_reg.burnout) == 2'h3, $past(src_reg.burnout) == 2'h2,
                         $past(src_reg.burnout) == 2'h1})
    else $error("burnout level decoded wrong");

  a_twos_select:
    assert property (##1 fe_cfg.twos_comp
                     == (!$past(ctrl_reg.fmt_offset) && !$past(ctrl_reg.unipolar)))
    else $error("two's complement not selected for bipolar format 0");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_ctrl_write:
    cover property (wr_en && wr_idx == CTRL_IDX ##1 bvalid && bready);

  c_bias_drops_exc:
    cover property (wr_en && wr_idx == BIAS_EN_IDX && (exc_en_reg & bias_en_next) != '0);

  c_exc_drops_bias:
    cover property (wr_en && wr_idx == EXC_EN_IDX && (bias_en_reg & exc_en_next) != '0);

  c_external_clock:
    cover property (fe_cfg.clk_ext && conv_tick);

  c_unmapped_read:
    cover property (rvalid && rresp == RESP_SLVERR);

endmodule : adc_fe_cfg

// [adc_fe_pkg.sv]
// shared constants, field layouts and decode helpers for the adc front-end config block
package adc_fe_pkg;
  // ----------------------------------------------------------------
  // register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] CTRL_IDX = 6'h09; // converter control
  localparam logic [5:0] SRC_IDX = 6'h0A; // bias / burnout / excitation source
  localparam logic [5:0] BIAS_EN_IDX = 6'h10; // per-input bias enables
  localparam logic [5:0] EXC_EN_IDX = 6'h11; // per-input excitation enables
  localparam logic [7:0] CTRL_RST = 8'h01; // reference pair 1 selected
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam int NUM_AIN = 12; // analog inputs with a bias / excitation switch
  localparam logic [NUM_AIN-1:0] EN_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REF_RESERVED = 3'h7;
  localparam logic [1:0] BIAS_ACTIVE = 2'h0;
  localparam logic [1:0] BIAS_HIGH_Z = 2'h1;
  localparam logic [1:0] BURN_OFF = 2'h0;
  localparam logic [10:0] EXC_MAX_UA = 11'h640; // 1600 microamps
  // control register layout, msb first
  typedef struct packed {
    logic clk_ext; // converter clocked from the external pin
    logic unipolar; // input range select
    logic fmt_offset; // offset binary when set
    logic refbuf_p; // p-side reference buffer on
    logic refbuf_n; // n-side reference buffer on
    logic [2:0] ref_sel; // reference pair
  } ctrl_fields_t;
  // source register layout, msb first
  typedef struct packed {
    logic [1:0] bias_mode;
    logic [1:0] burnout;
    logic [3:0] exc_level;
  } src_fields_t;
  // decoded front-end settings, all from flip-flops
  typedef struct packed {
    logic clk_ext;
    logic unipolar;
    logic twos_comp;
    logic offset_bin;
    logic refbuf_p_on;
    logic refbuf_p_bypass;
    logic refbuf_n_on;
    logic refbuf_n_bypass;
    logic [2:0] ref_code;
    logic ref_reserved;
    logic bias_active;
    logic bias_high_z;
    logic bias_low_z;
    logic burnout_on;
    logic [2:0] burnout_level; // one-hot while burnout is on, all zero when off: low, middle, high
    logic [10:0] exc_ua; // nominal excitation current in microamps
  } fe_cfg_t;
  // byte address to register index
  function automatic logic [5:0] addr_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : addr_idx
  // true where an index holds a register
  function automatic logic idx_mapped(input logic [5:0] i);
    return (i == CTRL_IDX) || (i == SRC_IDX) || (i == BIAS_EN_IDX) || (i == EXC_EN_IDX);
  endfunction : idx_mapped
  // excitation level code to nominal microamps, rising with the code
  function automatic logic [10:0] exc_ua_of(input logic [3:0] c);
    logic [10:0] t [16];
    t = '{11'h00A, 11'h032, 11'h04B, 11'h064, 11'h07D, 11'h096, 11'h0AF, 11'h0C8,
          11'h0E1, 11'h0FA, 11'h12C, 11'h190, 11'h258, 11'h320, 11'h4B0, EXC_MAX_UA};
    return t[c];
  endfunction : exc_ua_of
endpackage : adc_fe_pkg

// [axil_reg_slave.sv]
// axi4-lite slave front end: one write and one read in flight, register-side strobes
`timescale 1ns/1ps
module axil_reg_slave
  import adc_fe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [5:0] wr_idx,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [5:0] rd_idx,
  input wire logic [31:0] rd_data
);
  logic aw_full_reg; // address held until both halves are in
  logic w_full_reg; // data held until both halves are in
  // address and data may arrive in either order; both wait for the response
  assign awready = !aw_full_reg && !bvalid;
  assign wready = !w_full_reg && !bvalid;
  assign wr_en = aw_full_reg && w_full_reg && !bvalid;
  assign arready = !rvalid;
  assign rd_idx = addr_idx(araddr);
  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_idx <= 6'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        wr_idx <= addr_idx(awaddr);
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // read channel: data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : axil_reg_slave

// [fe_cfg_decode.sv]
// turns the two configuration bytes into registered front-end control lines
`timescale 1ns/1ps
module fe_cfg_decode
  import adc_fe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ctrl_fields_t ctrl,
  input wire src_fields_t src,
  output fe_cfg_t cfg
);
  fe_cfg_t cfg_next; // decoded value, registered below
  // field decode, shared by the live path and the reset value
  function automatic fe_cfg_t decode_fields(input ctrl_fields_t c, input src_fields_t s);
    fe_cfg_t d;
    d = '0;
    d.clk_ext = c.clk_ext;
    d.unipolar = c.unipolar;
    d.offset_bin = c.fmt_offset;
    d.twos_comp = !c.fmt_offset && !c.unipolar;
    d.refbuf_p_on = c.refbuf_p;
    d.refbuf_p_bypass = !c.refbuf_p;
    d.refbuf_n_on = c.refbuf_n;
    d.refbuf_n_bypass = !c.refbuf_n;
    d.ref_code = c.ref_sel;
    d.ref_reserved = c.ref_sel == REF_RESERVED;
    d.bias_active = s.bias_mode == BIAS_ACTIVE;
    d.bias_high_z = s.bias_mode == BIAS_HIGH_Z;
    d.bias_low_z = s.bias_mode[1]; // both upper codes
    d.burnout_on = s.burnout != BURN_OFF;
    d.burnout_level = 3'(s.burnout == 2'h1) | {1'b0, s.burnout == 2'h2, 1'b0}
                      | {s.burnout == 2'h3, 2'h0};
    d.exc_ua = exc_ua_of(s.exc_level);
    return d;
  endfunction : decode_fields
  // combinational field decode
  assign cfg_next = decode_fields(ctrl, src);
  // output register so the analog controls never glitch; reset loads the decode of the
  // reset bytes, so an all-zero setting with no bias mode never reaches the front end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= decode_fields(CTRL_RST, SRC_RST);
    end else begin
      cfg <= cfg_next;
    end
  end
endmodule : fe_cfg_decode

// [adc_frontend_config_regs_tb_top.sv]
// self-checking testbench for the adc front-end configuration block
`timescale 1ns/1ps
module adc_frontend_config_regs_tb_top import adc_fe_pkg::*;;
  // ----------------------------------------------------------------
  // signals and design under test
  // ----------------------------------------------------------------
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, internal_clk_tick, external_clock_pin, conv_tick;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  fe_cfg_t fe_cfg;
  logic [NUM_AIN-1:0] bias_en, exc_en;
  int bad_count = 0; // mismatches seen
  int samples_checked = 0; // comparisons made
  adc_fe_cfg u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .internal_clk_tick(internal_clk_tick), .external_clock_pin(external_clock_pin),
    .conv_tick(conv_tick), .fe_cfg(fe_cfg), .bias_en(bias_en), .exc_en(exc_en));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // expected decode worked out independently of the design's helpers
  function automatic fe_cfg_t exp_cfg(input logic [7:0] c, input logic [7:0] s);
    fe_cfg_t e;
    logic [10:0] ua [16];
    ua = '{11'h00A, 11'h032, 11'h04B, 11'h064, 11'h07D, 11'h096, 11'h0AF, 11'h0C8,
           11'h0E1, 11'h0FA, 11'h12C, 11'h190, 11'h258, 11'h320, 11'h4B0, 11'h640};
    e.clk_ext = c[7];
    e.unipolar = c[6];
    e.twos_comp = !c[5] && !c[6];
    e.offset_bin = c[5];
    e.refbuf_p_on = c[4];
    e.refbuf_p_bypass = !c[4];
    e.refbuf_n_on = c[3];
    e.refbuf_n_bypass = !c[3];
    e.ref_code = c[2:0];
    e.ref_reserved = (c[2:0] == 3'h7);
    e.bias_active = (s[7:6] == 2'h0);
    e.bias_high_z = (s[7:6] == 2'h1);
    e.bias_low_z = s[7];
    e.burnout_on = (s[5:4] != 2'h0);
    e.burnout_level = {s[5:4] == 2'h3, s[5:4] == 2'h2, s[5:4] == 2'h1};
    e.exc_ua = ua[s[3:0]];
    return e;
  endfunction : exp_cfg
  // write: both halves offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk); // lets the released strobes settle before the next request
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask : axr
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    axr(8'h24, 32'h01, RESP_OKAY);
    axr(8'h28, 32'h00, RESP_OKAY);
    chk(32'(fe_cfg), 32'(exp_cfg(8'h01, 8'h00)));
  endtask : t_reset
  // sweeps every reference, bias, burnout and excitation code
  task automatic t_decode;
    logic [7:0] c, s;
    for (int i = 0; i < 16; i++) begin
      c = {i[0], i[1], i[2], i[3], i[0], i[2:0]};
      s = {i[1:0], i[3:2], 4'(15 - i)};
      axw(8'h24, {24'h0, c}, RESP_OKAY);
      axw(8'h28, {24'h0, s}, RESP_OKAY);
      axr(8'h24, {24'h0, c}, RESP_OKAY);
      axr(8'h28, {24'h0, s}, RESP_OKAY);
      chk(32'(fe_cfg), 32'(exp_cfg(c, s)));
    end
  endtask : t_decode
  // turning one side on clears the other side on the same input
  task automatic t_exclusive;
    axw(8'h44, 32'h003, RESP_OKAY);
    axw(8'h40, 32'h001, RESP_OKAY);
    chk(32'(exc_en), 32'h002);
    chk(32'(bias_en), 32'h001);
    axw(8'h44, 32'h803, RESP_OKAY);
    chk(32'(bias_en), 32'h000);
    chk(32'(exc_en), 32'h803);
  endtask : t_exclusive
  task automatic t_unmapped;
    axw(8'h00, 32'hFF, RESP_SLVERR);
    axr(8'h00, 32'h0, RESP_SLVERR);
    axr(8'h24, 32'hFF, RESP_OKAY);
    axr(8'h28, 32'hF0, RESP_OKAY);
  endtask : t_unmapped
  // internal tick passes straight through; with the pin selected, one pin edge gives one tick and the internal tick none
  task automatic t_conv_clock;
    int n = 0;
    axw(8'h24, 32'h01, RESP_OKAY);
    internal_clk_tick <= 1'b1;
    @(posedge aclk);
    chk(32'(conv_tick), 32'h1);
    internal_clk_tick <= 1'b0;
    axw(8'h24, 32'h81, RESP_OKAY);
    external_clock_pin <= 1'b1;
    internal_clk_tick <= 1'b1;
    repeat (6) begin
      @(posedge aclk);
      internal_clk_tick <= 1'b0;
      n += int'(conv_tick === 1'b1);
    end
    chk(32'(n), 32'h1);
    external_clock_pin <= 1'b0;
  endtask : t_conv_clock
  // ----------------------------------------------------------------
  // clock, reset, sequence and verdict
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // watchdog: the full sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {internal_clk_tick, external_clock_pin, awaddr, araddr, wdata, wstrb} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_decode();
    t_exclusive();
    t_unmapped();
    t_conv_clock();
    give_verdict();
  end
endmodule : adc_frontend_config_regs_tb_top
